// [hdl/core_flags_regs.svh]
// Offsets, field positions, reset values and address widths of the core flag block.
// Assumes inclusion by its bare name from the package and the core flag module.
`ifndef CORE_FLAGS_REGS_SVH
`define CORE_FLAGS_REGS_SVH
`define CORE_FLAGS_OFFSET     4'h0
`define RESET_CAUSE_OFFSET    4'h1
`define IRQ_STATUS_OFFSET     4'h2
`define IRQ_CLEAR_OFFSET      4'h3
`define IRQ_ENABLE_OFFSET     4'h4
`define CONTROL_OFFSET        4'h5
`define ADDR_WIDTH            4
`define INDIRECT_BANK_BIT     7
`define DIRECT_BANK_HI_BIT    6
`define DIRECT_BANK_LO_BIT    5
`define WATCHDOG_EXPIRED_BIT  4
`define POWERED_DOWN_BIT      3
`define ZERO_RESULT_BIT       2
`define PARITY_PRESENT_BIT    7
`define PARITY_RESET_BIT      2
`define POWERON_RESET_BIT     1
`define BROWNOUT_RESET_BIT    0
`define CORE_FLAGS_RESET      8'h18
`define RESET_CAUSE_RESET     8'h00
`define CONTROL_BANK23_BIT    0
`define IRQ_POWERON_BIT       0
`define IRQ_BROWNOUT_BIT      1
`define IRQ_PARITY_BIT        2
`define IRQ_WATCHDOG_BIT      3
`define IRQ_EXT_BIT           4
`define IRQ_WIDTH             5
`endif

// [hdl/core_flags_pkg.sv]
// Types shared by the core flag block and its testbench.
// Assumes the register header is on the include path.
`include "core_flags_regs.svh"
package core_flags_pkg;
    // Reset sources that can act on the flags.
    typedef struct packed {
        logic power_on;
        logic brown_out;
        logic parity_error;
        logic watchdog_timeout;
        logic external_pin;
    } reset_event_type;
    // Core instruction events that touch the flags.
    typedef struct packed {
        logic watchdog_clear;
        logic halt;
        logic result_valid;
        logic [7:0] result;
    } core_event_type;
    typedef struct packed {
        logic [`ADDR_WIDTH-1:0] addr;
        logic [7:0]             wdata;
        logic                   write;
        logic                   read;
    } reg_req_type;
    typedef enum logic [1:0] {
        RUN_STATE,
        HALT_STATE
    } core_state_type;
endpackage

// [hdl/pin_sync3.sv]
// Three-stage synchroniser for one asynchronous pin, with a one-cycle rising-event output.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module pin_sync3 (
    input  wire logic ref_clk_in,
    input  wire logic reset_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       level_reg;
    logic       level_next;

    // A change counts only once the second and third stages agree.
    always_comb begin
        stage_next = {stage_reg[1:0], pin_in};
        level_next = level_reg;
        if (stage_reg[2] == stage_reg[1]) begin
            level_next = stage_reg[2];
        end
    end

    // Registers only.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            stage_reg <= 3'h0;
            level_reg <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;
    assign rise_out  = level_next & ~level_reg;
endmodule // pin_sync3

// [hdl/core_flags_reset_cause.sv]
// Core flag and reset-cause logic: bank selects, zero flag, watchdog and power-down flags, reset causes.
// Assumes reset sources arrive as asynchronous pins and core events on the core clock.
`timescale 1ns/1ns
`include "core_flags_regs.svh"
module core_flags_reset_cause
    import core_flags_pkg::*;
(
    input  wire logic                   ref_clk_in,
    input  wire logic                   reset_in,
    input  wire logic                   power_on_pin_in,
    input  wire logic                   brown_out_pin_in,
    input  wire logic                   parity_error_pin_in,
    input  wire logic                   watchdog_timeout_in,
    input  wire logic                   external_reset_pin_in,
    input  wire logic                   parity_check_config_in,
    input  core_flags_pkg::core_event_type core_event_in,
    input  wire logic [6:0]             direct_field_in,
    input  wire logic [7:0]             indirect_pointer_in,
    input  core_flags_pkg::reg_req_type reg_req_in,
    output logic [7:0]                  reg_rdata_out,
    output logic [8:0]                  direct_address_out,
    output logic [8:0]                  indirect_address_out,
    output logic                        irq_out
);
    import core_flags_pkg::*;

    reset_event_type      rst_ev;
    logic [7:0]           flags_reg;
    logic [7:0]           flags_next;
    logic [2:0]           cause_reg;
    logic [2:0]           cause_next;
    logic                 parity_cfg_reg;
    logic [`IRQ_WIDTH-1:0] irq_status_reg;
    logic [`IRQ_WIDTH-1:0] irq_status_next;
    logic [`IRQ_WIDTH-1:0] irq_enable_reg;
    logic [`IRQ_WIDTH-1:0] irq_enable_next;
    logic                 two_bank_reg;
    logic                 two_bank_next;
    logic [7:0]           rdata_reg;
    logic [7:0]           rdata_next;
    logic [8:0]           daddr_reg;
    logic [8:0]           iaddr_reg;
    core_state_type       state_reg;
    core_state_type       state_next;
    logic [4:0]           ext_pins;

    // Decode of a register offset, used by the write paths; the read mux decodes with its own case.
    function automatic logic hit(input logic [`ADDR_WIDTH-1:0] a, input logic [`ADDR_WIDTH-1:0] off);
        hit = (a == off);
    endfunction

    // Every reset source is an asynchronous pin; one synchroniser per source.
    assign ext_pins = {power_on_pin_in, brown_out_pin_in, parity_error_pin_in,
                       watchdog_timeout_in, external_reset_pin_in};
    logic [4:0] pin_rise;
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_sync
            pin_sync3 u_sync (
                .ref_clk_in (ref_clk_in),
                .reset_in   (reset_in),
                .pin_in     (ext_pins[g]),
                .level_out  (),
                .rise_out   (pin_rise[g])
            );
        end
    endgenerate
    assign rst_ev = reset_event_type'(pin_rise);

    // Run and halt tracking; a halt ends on any reset or watchdog wake.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RUN_STATE: begin
                if (core_event_in.halt) begin
                    state_next = HALT_STATE;
                end
            end
            HALT_STATE: begin
                if (|pin_rise) begin
                    state_next = RUN_STATE;
                end
            end
            default: begin
                state_next = RUN_STATE;
            end
        endcase
    end

    // Flag updates; reset events take priority over instruction events.
    always_comb begin
        flags_next = flags_reg;
        cause_next = cause_reg;
        if (core_event_in.result_valid) begin
            flags_next[`ZERO_RESULT_BIT] = (core_event_in.result == 8'h00);
        end
        if (core_event_in.watchdog_clear) begin
            flags_next[`WATCHDOG_EXPIRED_BIT] = 1'b1;
            flags_next[`POWERED_DOWN_BIT]     = 1'b1;
        end
        if (core_event_in.halt) begin
            flags_next[`WATCHDOG_EXPIRED_BIT] = 1'b1;
            flags_next[`POWERED_DOWN_BIT]     = 1'b0;
        end
        if (reg_req_in.write && hit(reg_req_in.addr, `CORE_FLAGS_OFFSET)) begin
            // Software owns bank bits and zero flag; the watchdog-expired and powered-down flags are read-only.
            flags_next[7:5] = reg_req_in.wdata[7:5];
            if (two_bank_reg) begin
                flags_next[`INDIRECT_BANK_BIT] = 1'b0;
            end
            flags_next[`ZERO_RESULT_BIT] = reg_req_in.wdata[`ZERO_RESULT_BIT];
            flags_next[1:0] = reg_req_in.wdata[1:0];
        end
        if (reg_req_in.write && hit(reg_req_in.addr, `RESET_CAUSE_OFFSET)) begin
            cause_next = reg_req_in.wdata[2:0];
        end
        // Reset events; hardware clears win over a software write in the same cycle.
        if (rst_ev.watchdog_timeout) begin
            flags_next[`WATCHDOG_EXPIRED_BIT] = 1'b0;
        end
        if (rst_ev.external_pin && state_reg == HALT_STATE) begin
            flags_next[`WATCHDOG_EXPIRED_BIT] = 1'b1;
            flags_next[`POWERED_DOWN_BIT]     = 1'b0;
        end
        if (rst_ev.parity_error) begin
            cause_next[`PARITY_RESET_BIT] = 1'b0;
        end
        if (rst_ev.brown_out) begin
            cause_next[`BROWNOUT_RESET_BIT] = 1'b0;
        end
        if (rst_ev.power_on) begin
            flags_next = `CORE_FLAGS_RESET;
            cause_next = 3'h0;
        end
    end

    // Interrupt status: set wins over clear.
    always_comb begin
        irq_status_next = irq_status_reg;
        irq_enable_next = irq_enable_reg;
        two_bank_next   = two_bank_reg;
        if (reg_req_in.write && hit(reg_req_in.addr, `IRQ_CLEAR_OFFSET)) begin
            irq_status_next = irq_status_reg & ~reg_req_in.wdata[`IRQ_WIDTH-1:0];
        end
        if (reg_req_in.write && hit(reg_req_in.addr, `IRQ_ENABLE_OFFSET)) begin
            irq_enable_next = reg_req_in.wdata[`IRQ_WIDTH-1:0];
        end
        if (reg_req_in.write && hit(reg_req_in.addr, `CONTROL_OFFSET)) begin
            two_bank_next = reg_req_in.wdata[`CONTROL_BANK23_BIT];
        end
        irq_status_next = irq_status_next | {rst_ev.external_pin, rst_ev.watchdog_timeout,
                                             rst_ev.parity_error, rst_ev.brown_out, rst_ev.power_on};
    end

    // Read mux; unmapped offsets read zero.
    always_comb begin
        rdata_next = 8'h00;
        if (reg_req_in.read) begin
            case (reg_req_in.addr)
                `CORE_FLAGS_OFFSET:  rdata_next = flags_reg;
                `RESET_CAUSE_OFFSET: rdata_next = {parity_cfg_reg, 4'h0, cause_reg};
                `IRQ_STATUS_OFFSET:  rdata_next = {3'h0, irq_status_reg};
                `IRQ_ENABLE_OFFSET:  rdata_next = {3'h0, irq_enable_reg};
                `CONTROL_OFFSET:     rdata_next = {7'h00, two_bank_reg};
                default:             rdata_next = 8'h00;
            endcase
        end
    end

    // Registers only; reset_in gives flags and causes their power-on values and clears every other register.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            flags_reg      <= `CORE_FLAGS_RESET;
            cause_reg      <= 3'h0;
            parity_cfg_reg <= 1'b0;
            irq_status_reg <= 5'h00;
            irq_enable_reg <= 5'h00;
            two_bank_reg   <= 1'b0;
            rdata_reg      <= 8'h00;
            daddr_reg      <= 9'h000;
            iaddr_reg      <= 9'h000;
            state_reg      <= RUN_STATE;
        end else begin
            flags_reg      <= flags_next;
            cause_reg      <= cause_next;
            parity_cfg_reg <= parity_check_config_in;
            irq_status_reg <= irq_status_next;
            irq_enable_reg <= irq_enable_next;
            two_bank_reg   <= two_bank_next;
            rdata_reg      <= rdata_next;
            daddr_reg      <= {flags_reg[6:5], direct_field_in};
            iaddr_reg      <= {flags_reg[`INDIRECT_BANK_BIT], indirect_pointer_in};
            state_reg      <= state_next;
        end
    end

    assign reg_rdata_out        = rdata_reg;
    assign direct_address_out   = daddr_reg;
    assign indirect_address_out = iaddr_reg;
    assign irq_out              = |(irq_status_reg & irq_enable_reg);

    // Flag checks. Each looks one edge after its trigger, once the registers have taken the update.
    a_timeout_clears: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.watchdog_timeout && !rst_ev.power_on |=> !flags_reg[`WATCHDOG_EXPIRED_BIT])
        else $error("watchdog flag not cleared");
    a_halt_clears_pd: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        core_event_in.halt && !(|pin_rise) |=> !flags_reg[`POWERED_DOWN_BIT] && flags_reg[`WATCHDOG_EXPIRED_BIT])
        else $error("halt flags wrong");
    a_clear_sets_pd: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        core_event_in.watchdog_clear && !core_event_in.halt && !(|pin_rise) |=> flags_reg[4:3] == 2'b11)
        else $error("watchdog clear flags wrong");
    a_zero_flag: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        core_event_in.result_valid && !reg_req_in.write && !rst_ev.power_on
        |=> flags_reg[`ZERO_RESULT_BIT] == ($past(core_event_in.result) == 8'h00))
        else $error("zero flag wrong");
    a_wdt_keeps_pd: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.watchdog_timeout && !rst_ev.power_on && !rst_ev.external_pin && !core_event_in.halt
        && !core_event_in.watchdog_clear |=> $stable(flags_reg[`POWERED_DOWN_BIT]))
        else $error("watchdog reset changed powered-down flag");
    a_flags_readonly: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        reg_req_in.write && reg_req_in.addr == `CORE_FLAGS_OFFSET && !(|pin_rise) && !core_event_in.halt
        && !core_event_in.watchdog_clear |=> $stable(flags_reg[4:3]))
        else $error("software changed read-only flags");
    a_two_bank_forced: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        two_bank_reg && reg_req_in.write && reg_req_in.addr == `CORE_FLAGS_OFFSET && !rst_ev.power_on
        |=> !flags_reg[`INDIRECT_BANK_BIT])
        else $error("indirect bank bit set on two-bank part");

    // Reset-cause checks. Hardware clears must win over software writes in the same cycle.
    a_parity_mirror: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        reg_req_in.read && reg_req_in.addr == `RESET_CAUSE_OFFSET |=> reg_rdata_out[7] == $past(parity_cfg_reg))
        else $error("parity mirror wrong");
    a_cause_upper_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        reg_req_in.read && reg_req_in.addr == `RESET_CAUSE_OFFSET |=> reg_rdata_out[6:3] == 4'h0)
        else $error("unused cause bits not zero");
    a_parity_reset: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.parity_error |=> !cause_reg[`PARITY_RESET_BIT])
        else $error("parity flag not cleared");
    a_poweron_flags: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.power_on |=> flags_reg[4:3] == 2'b11 && !cause_reg[`POWERON_RESET_BIT])
        else $error("power-on flags wrong");
    a_poweron_value: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.power_on |=> flags_reg == `CORE_FLAGS_RESET && cause_reg == 3'h0)
        else $error("power-on register values wrong");
    a_brownout_reset: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.brown_out |=> !cause_reg[`BROWNOUT_RESET_BIT])
        else $error("brown-out flag not cleared");
    a_ext_running: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.external_pin && state_reg == RUN_STATE && !rst_ev.power_on && !rst_ev.watchdog_timeout
        && !core_event_in.halt && !core_event_in.watchdog_clear |=> $stable(flags_reg[4:3]))
        else $error("external reset changed flags");
    a_ext_halted: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.external_pin && state_reg == HALT_STATE && !rst_ev.power_on && !rst_ev.watchdog_timeout
        |=> flags_reg[4:3] == 2'b10)
        else $error("external reset during halt gave wrong flags");
    a_halt_enters: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        core_event_in.halt && state_reg == RUN_STATE |=> state_reg == HALT_STATE)
        else $error("halt not tracked");
    a_halt_wakes: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state_reg == HALT_STATE && (|pin_rise) |=> state_reg == RUN_STATE)
        else $error("reset did not end halt");
    a_ext_keeps_por: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (rst_ev.external_pin || rst_ev.watchdog_timeout) && !rst_ev.power_on && !rst_ev.brown_out
        && !reg_req_in.write |=> $stable(cause_reg[1:0]))
        else $error("cause flags disturbed");
    a_brownout_keeps_por: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.brown_out && !rst_ev.power_on && !reg_req_in.write |=> $stable(cause_reg[`POWERON_RESET_BIT]))
        else $error("brown-out changed power-on flag");

    // Address outputs lag their sources by one edge, so each output is compared with its sources taken through $past.
    a_direct_addr: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        1'b1 |=> direct_address_out == {$past(flags_reg[6:5]), $past(direct_field_in)})
        else $error("direct address wrong");
    a_indirect_addr: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        1'b1 |=> indirect_address_out == {$past(flags_reg[`INDIRECT_BANK_BIT]), $past(indirect_pointer_in)})
        else $error("indirect address wrong");

    // Bus and interrupt checks; read data may stand for one cycle only, so idle cycles must read zero.
    a_rdata_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !reg_req_in.read |=> reg_rdata_out == 8'h00)
        else $error("read data outside read cycle");
    a_irq_sticky: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rst_ev.parity_error |=> irq_status_reg[`IRQ_PARITY_BIT])
        else $error("parity event not recorded");
    a_irq_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        reg_req_in.write && reg_req_in.addr == `IRQ_CLEAR_OFFSET && reg_req_in.wdata[`IRQ_PARITY_BIT]
        && !rst_ev.parity_error |=> !irq_status_reg[`IRQ_PARITY_BIT])
        else $error("status bit not cleared");

    // Coverage of the main scenarios.
    c_halt_wake: cover property (@(posedge ref_clk_in) state_reg == HALT_STATE ##1 state_reg == RUN_STATE);
    c_poweron: cover property (@(posedge ref_clk_in) rst_ev.power_on);
    c_irq: cover property (@(posedge ref_clk_in) irq_out);
    c_ext_halted: cover property (@(posedge ref_clk_in) rst_ev.external_pin && state_reg == HALT_STATE);
    c_two_bank: cover property (@(posedge ref_clk_in) two_bank_reg && reg_req_in.write);
endmodule // core_flags_reset_cause

// [tb/core_flags_reset_cause_tb.sv]
// Self-checking bench for the core flag and reset-cause block, with integer models of causes and irq status.
// Assumes the package and register header compile first; the bench drives every port of the block itself.
`timescale 1ns/1ns
module core_flags_reset_cause_tb;
    import core_flags_pkg::*;
    logic           ref_clk_in;
    logic           reset_in;
    logic [4:0]     pins;
    logic           cfg;
    core_event_type ev;
    logic [6:0]     field;
    logic [7:0]     ptr;
    reg_req_type    req;
    logic [7:0]     rdata;
    logic [8:0]     daddr;
    logic [8:0]     iaddr;
    logic           irq;
    logic [31:0]    seed;
    logic [7:0]     r;
    int             n_mismatch;
    int             cmp_count;
    int             cycles;
    int             cs;
    int             st;

    // Pin vector index matches the irq status layout, so one shift models both.
    core_flags_reset_cause dut (
        .ref_clk_in             (ref_clk_in),
        .reset_in               (reset_in),
        .power_on_pin_in        (pins[0]),
        .brown_out_pin_in       (pins[1]),
        .parity_error_pin_in    (pins[2]),
        .watchdog_timeout_in    (pins[3]),
        .external_reset_pin_in  (pins[4]),
        .parity_check_config_in (cfg),
        .core_event_in          (ev),
        .direct_field_in        (field),
        .indirect_pointer_in    (ptr),
        .reg_req_in             (req),
        .reg_rdata_out          (rdata),
        .direct_address_out     (daddr),
        .indirect_address_out   (iaddr),
        .irq_out                (irq)
    );

    // Free-running core clock at 100 MHz.
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // A hang is cut short at 5000 cycles, well beyond the few hundred cycles the tests need.
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe; the leading edge wait keeps back-to-back calls from double assignment.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge ref_clk_in);
        req.write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
    task automatic rd(input logic [3:0] a, input int exp, input int mask);
        @(posedge ref_clk_in);
        req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge ref_clk_in);
        req.read <= 1'b0;
        #1;
        chk({8'h00, rdata & mask[7:0]}, 16'(exp & mask));
    endtask

    // Pins are held two cycles, then the synchroniser and flag update are given ample time.
    task automatic pulse(input int k);
        @(posedge ref_clk_in);
        pins[k] <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        pins[k] <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        st = st | (1 << k);
    endtask

    task automatic core(input logic c, input logic h, input logic v, input logic [7:0] res);
        @(posedge ref_clk_in);
        ev <= '{watchdog_clear: c, halt: h, result_valid: v, result: res};
        @(posedge ref_clk_in);
        ev <= '0;
        repeat (2) @(posedge ref_clk_in);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence: reset values, banking, zero flag, cause bits with irq, power flags, power-on.
    initial begin
        reset_in = 1'b1;
        pins = 5'h00;
        cfg = 1'b0;
        ev = '0;
        field = 7'h00;
        ptr = 8'h00;
        req = '0;
        seed = 32'd27;
        n_mismatch = 0;
        cmp_count = 0;
        cycles = 0;
        cs = 0;
        st = 0;
        repeat (10) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        rd(4'h0, 8'h18, 8'hff);
        rd(4'h1, 8'h00, 8'hff);
        rd(4'h2, 8'h00, 8'hff);
        $display("Test reset values done");
        for (int b = 0; b < 8; b++) begin
            wr(4'h0, 8'(b << 5));
            field <= 7'(rnd());
            ptr <= 8'(rnd());
            repeat (2) @(posedge ref_clk_in);
            #1;
            chk({7'h00, daddr}, {7'h00, b[1:0], field});
            chk({7'h00, iaddr}, {7'h00, b[2], ptr});
            rd(4'h0, (b << 5) | 8'h18, 8'hf8);
        end
        // Software clears the indirect bank bit before marking a two-bank part, then keeps it clear.
        wr(4'h0, 8'h18);
        wr(4'h5, 8'h01);
        wr(4'h0, 8'h60);
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk({15'h0000, iaddr[8]}, 16'h0000);
        chk({14'h0000, daddr[8:7]}, 16'h0003);
        rd(4'h5, 8'h01, 8'hff);
        wr(4'h5, 8'h00);
        wr(4'h0, 8'h00);
        $display("Test banking done");
        for (int i = 0; i < 6; i++) begin
            r = (i % 2 == 1) ? 8'(rnd() | 1) : 8'h00;
            core(1'b0, 1'b0, 1'b1, r);
            rd(4'h0, (r == 8'h00) ? 8'h04 : 8'h00, 8'h04);
        end
        $display("Test zero flag done");
        wr(4'h1, 8'hff);
        cs = 7;
        rd(4'h1, cs, 8'hff);
        cfg <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        rd(4'h1, 8'h80 | cs, 8'hff);
        wr(4'h4, 8'h04);
        pulse(2);
        cs = cs & 3;
        rd(4'h1, 8'h80 | cs, 8'hff);
        chk({15'h0000, irq}, 16'h0001);
        pulse(1);
        cs = cs & 6;
        rd(4'h1, 8'h80 | cs, 8'hff);
        rd(4'h2, st, 8'h1f);
        wr(4'h3, 8'h04);
        st = st & ~4;
        #1;
        chk({15'h0000, irq}, 16'h0000);
        rd(4'h2, st, 8'h1f);
        rd(4'hf, 8'h00, 8'hff);
        $display("Test reset cause done");
        pulse(3);
        rd(4'h0, 8'h08, 8'h18);
        pulse(4);
        rd(4'h0, 8'h08, 8'h18);
        rd(4'h1, cs, 8'h03);
        core(1'b0, 1'b1, 1'b0, 8'h00);
        rd(4'h0, 8'h10, 8'h18);
        pulse(4);
        rd(4'h0, 8'h10, 8'h18);
        core(1'b1, 1'b0, 1'b0, 8'h00);
        rd(4'h0, 8'h18, 8'h18);
        core(1'b1, 1'b1, 1'b0, 8'h00);
        rd(4'h0, 8'h10, 8'h18);
        rd(4'h2, st, 8'h1f);
        $display("Test power flags done");
        pulse(0);
        rd(4'h0, 8'h18, 8'hff);
        rd(4'h1, 8'h80, 8'hff);
        rd(4'h2, 8'h01, 8'h01);
        wr(4'h1, 8'h07);
        rd(4'h1, 8'h87, 8'hff);
        $display("Test power-on done");
        end_sim();
    end
endmodule // core_flags_reset_cause_tb
